/* common/sgp_pkg.sv */
// Shared constants for the GPIO port block
package sgp_pkg;
  // Port geometry
  localparam int NPORT = 7;
  localparam int PW = 8;
  localparam int NBIT = NPORT * PW;
  // Implemented pins per port, port G in the top byte, port A at the bottom
  localparam logic [55:0] IMPL_MASK = 56'h7F_73_FF_0F_3F_0F_87;
  // Pins that carry a pulldown as well as a pullup
  localparam logic [55:0] PD_CAP_MASK = 56'h10_00_00_0C_00_00_00;
  // APB address layout
  localparam int AW = 12;
  localparam logic [3:0] PAGE_ZERO = 4'h0;
  localparam logic [3:0] PAGE_HIGH = 4'h1;
  // Page zero: 8-byte stride per port, data then direction
  localparam logic [2:0] OFF_DATA = 3'h0;
  localparam logic [2:0] OFF_DIR = 3'h4;
  // High page: 16-byte stride per port, pullup, slew, drive
  localparam logic [3:0] OFF_PE = 4'h0;
  localparam logic [3:0] OFF_SE = 4'h4;
  localparam logic [3:0] OFF_DS = 4'h8;
  // Reset values; data and slew masked by implemented bits when loaded
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [7:0] SE_RST = 8'hFF;
  localparam logic [7:0] DS_RST = 8'h00;
  localparam logic [7:0] PE_RST = 8'h00;
  // Timer external clock pins on port D
  localparam int TMR1_CLK_BIT = 3 * PW + 0;
  localparam int TMR2_CLK_BIT = 3 * PW + 1;
endpackage

/* verilog/sgp_sync.sv */
// Two-flop synchroniser for pin levels
`timescale 1ns/1ns
module sgp_sync #(
  parameter int W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // First stage, read only by the second
  logic [W-1:0] meta_q;

  // Both stages clear at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

/* verilog/sgp_cell.sv */
// Per-port pad control and ownership resolution
`timescale 1ns/1ns
module sgp_cell #(
  parameter logic [7:0] IMPL = 8'hFF,
  parameter logic [7:0] PDCAP = 8'h00
) (
  input wire logic [7:0] dat,
  input wire logic [7:0] dir,
  input wire logic [7:0] pe,
  input wire logic [7:0] pin_sync,
  input wire logic [7:0] func_en,
  input wire logic [7:0] func_oe,
  input wire logic [7:0] func_out,
  input wire logic [7:0] analog_en,
  input wire logic [7:0] keypad_pin_enable,
  input wire logic [7:0] keypad_edge_select,
  output logic [7:0] drive_en,
  output logic [7:0] drive_val,
  output logic [7:0] pull_up,
  output logic [7:0] pull_dn,
  output logic [7:0] rd_data
);
  // Ownership terms
  logic [7:0] ana;
  logic [7:0] dig;
  logic [7:0] own_out;
  logic [7:0] pd_sel;

  // Analog claim beats any digital function
  assign ana = analog_en & IMPL;
  // Peripheral owns the pin only if analog does not
  assign dig = func_en & ~ana & IMPL;
  // Peripheral direction replaces the direction bit
  assign own_out = dig & func_oe;
  // Driver enable; no digital drive under analog
  assign drive_en = (own_out | (~func_en & dir)) & ~ana & IMPL;
  // Peripheral data wins where it drives
  assign drive_val = ((own_out & func_out) | (~own_out & dat)) & IMPL;
  // Pulldown for rising-edge keypad sensing
  assign pd_sel = PDCAP & keypad_pin_enable & keypad_edge_select & ~ana;
  assign pull_dn = pd_sel & IMPL;
  // Pullup off for outputs, analog, or pulldown selected
  assign pull_up = pe & ~drive_en & ~ana & ~pd_sel & IMPL;
  // Direction bit picks live pin or latch; analog reads zero
  assign rd_data = ((dir & dat) | (~dir & pin_sync)) & ~ana & IMPL;
endmodule

/* verilog/sgp_gpio.sv */
// Seven-port GPIO block with APB registers and peripheral sharing
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ns
// Function
// - 38 pins in seven ports, data and direction
// - Reset leaves pins under parallel I/O
// - Reset clears every direction bit
// - Reset: slew on, low drive, no pullup
// - Idle peripheral returns pin to GPIO
// - Per-port pin counts; other bits reserved
// - Data/direction page zero; pad controls high
// - ADC-selected port B pin loses digital I/O
// - Third timer sets port B direction
// - Serial, I2C, clock out set C direction
// - Peripheral output data replaces port data
// - ADC or keypad sets port D direction
// - ADC wins over digital peripheral
// - Port D carries timer external clocks
// - Rising keypad sensing selects pulldown
// - Data read: pin if input, latch if output
// - Analog pins read zero, digital disabled
// - Pullup off for outputs and analog
module sgp_gpio (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [55:0] pin_in,
  output logic [55:0] pin_out,
  output logic [55:0] pin_oe_n,
  output logic [55:0] pin_pullup,
  output logic [55:0] pin_pulldown,
  output logic [55:0] pin_slew,
  output logic [55:0] pin_drive,
  input wire logic [55:0] func_en,
  input wire logic [55:0] func_oe,
  input wire logic [55:0] func_out,
  input wire logic [55:0] analog_en,
  input wire logic [55:0] keypad_pin_enable,
  input wire logic [55:0] keypad_edge_select,
  output logic [55:0] func_in,
  output logic first_timer_module_clk,
  output logic second_timer_module_clk
);
  // Software registers, one byte per port
  logic [55:0] port_data_register_q;
  logic [55:0] pin_direction_bit_q;
  logic [55:0] pullup_enable_bit_q;
  logic [55:0] slew_limit_enable_bit_q;
  logic [55:0] drive_strength_bit_q;
  // Synchronised pin levels
  logic [55:0] pin_sync;
  // Combinational pad controls from the cells
  logic [55:0] drv_en_d;
  logic [55:0] drv_val_d;
  logic [55:0] pu_d;
  logic [55:0] pd_d;
  logic [55:0] rd_pin_d;
  // Bus decode
  logic [3:0] page;
  logic [3:0] z_port;
  logic [3:0] h_port;
  logic hit;
  logic is_dat;
  logic is_dir;
  logic is_pe;
  logic is_se;
  logic is_ds;
  logic [2:0] sel_port;
  logic [7:0] sel_impl;
  logic [7:0] rd_val;
  logic setup_ph;
  logic wr_go;
  logic [7:0] wbyte;

  // Pin inputs cross into the bus clock
  sgp_sync #(
    .W(56)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(pin_in),
    .q(pin_sync)
  );

  // One resolution cell per port
  genvar gp;
  generate
    for (gp = 0; gp < sgp_pkg::NPORT; gp++) begin : g_port
      sgp_cell #(
        .IMPL(sgp_pkg::IMPL_MASK[gp*8 +: 8]),
        .PDCAP(sgp_pkg::PD_CAP_MASK[gp*8 +: 8])
      ) u_cell (
        .dat(port_data_register_q[gp*8 +: 8]),
        .dir(pin_direction_bit_q[gp*8 +: 8]),
        .pe(pullup_enable_bit_q[gp*8 +: 8]),
        .pin_sync(pin_sync[gp*8 +: 8]),
        .func_en(func_en[gp*8 +: 8]),
        .func_oe(func_oe[gp*8 +: 8]),
        .func_out(func_out[gp*8 +: 8]),
        .analog_en(analog_en[gp*8 +: 8]),
        .keypad_pin_enable(keypad_pin_enable[gp*8 +: 8]),
        .keypad_edge_select(keypad_edge_select[gp*8 +: 8]),
        .drive_en(drv_en_d[gp*8 +: 8]),
        .drive_val(drv_val_d[gp*8 +: 8]),
        .pull_up(pu_d[gp*8 +: 8]),
        .pull_dn(pd_d[gp*8 +: 8]),
        .rd_data(rd_pin_d[gp*8 +: 8])
      );
    end
  endgenerate

  // Address fields of the two register pages
  assign page = paddr[11:8];
  assign z_port = {1'b0, paddr[5:3]};
  assign h_port = paddr[7:4];

  // Page-zero and high-page decode
  always_comb begin
    is_dat = 1'b0;
    is_dir = 1'b0;
    is_pe = 1'b0;
    is_se = 1'b0;
    is_ds = 1'b0;
    sel_port = 3'h0;
    // Word aligned only
    if (paddr[1:0] == 2'h0) begin
      // Data and direction live in page zero
      if (page == sgp_pkg::PAGE_ZERO && paddr[7:6] == 2'h0 && z_port != 4'h7) begin
        sel_port = z_port[2:0];
        is_dat = ({1'b0, paddr[2:0]} == {1'b0, sgp_pkg::OFF_DATA});
        is_dir = (paddr[2:0] == sgp_pkg::OFF_DIR);
      // Pad controls live in the high page
      end else if (page == sgp_pkg::PAGE_HIGH && h_port < 4'h7) begin
        sel_port = h_port[2:0];
        is_pe = (paddr[3:0] == sgp_pkg::OFF_PE);
        is_se = (paddr[3:0] == sgp_pkg::OFF_SE);
        is_ds = (paddr[3:0] == sgp_pkg::OFF_DS);
      end else begin
        // Unmapped: no select
        sel_port = 3'h0;
      end
    end
    hit = is_dat | is_dir | is_pe | is_se | is_ds;
  end

  // Implemented bits of the addressed port
  assign sel_impl = sgp_pkg::IMPL_MASK[sel_port*8 +: 8];
  // Writes keep reserved positions at zero
  assign wbyte = pwdata[7:0] & sel_impl;

  // Read value of the addressed register
  always_comb begin
    rd_val = 8'h00;
    if (is_dat) begin
      // Live pin or latch per direction bit
      rd_val = rd_pin_d[sel_port*8 +: 8];
    end else if (is_dir) begin
      rd_val = pin_direction_bit_q[sel_port*8 +: 8];
    end else if (is_pe) begin
      rd_val = pullup_enable_bit_q[sel_port*8 +: 8];
    end else if (is_se) begin
      rd_val = slew_limit_enable_bit_q[sel_port*8 +: 8];
    end else if (is_ds) begin
      rd_val = drive_strength_bit_q[sel_port*8 +: 8];
    end else begin
      // Unmapped reads zero
      rd_val = 8'h00;
    end
  end

  // Setup phase and committed write
  assign setup_ph = psel & ~penable;
  assign wr_go = psel & penable & pready & pwrite & hit;

  // APB answer: ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (setup_ph) begin
      // Answer prepared at the setup edge
      pready <= 1'b1;
      pslverr <= ~hit;
      // Upper bits always zero
      prdata <= {24'h00_0000, rd_val};
    end else begin
      // One-cycle answer
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
  end

  // Port data latch; written even while a peripheral owns the pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_data_register_q <= {sgp_pkg::NPORT{sgp_pkg::DATA_RST}} & sgp_pkg::IMPL_MASK;
    end else if (wr_go && is_dat) begin
      port_data_register_q[sel_port*8 +: 8] <= wbyte;
    end
  end

  // Direction bits; all inputs after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_direction_bit_q <= {sgp_pkg::NPORT{sgp_pkg::DIR_RST}};
    end else if (wr_go && is_dir) begin
      pin_direction_bit_q[sel_port*8 +: 8] <= wbyte;
    end
  end

  // Pullup enables; off after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pullup_enable_bit_q <= {sgp_pkg::NPORT{sgp_pkg::PE_RST}};
    end else if (wr_go && is_pe) begin
      pullup_enable_bit_q[sel_port*8 +: 8] <= wbyte;
    end
  end

  // Slew limiting; on after reset for implemented pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slew_limit_enable_bit_q <= {sgp_pkg::NPORT{sgp_pkg::SE_RST}} & sgp_pkg::IMPL_MASK;
    end else if (wr_go && is_se) begin
      slew_limit_enable_bit_q[sel_port*8 +: 8] <= wbyte;
    end
  end

  // Drive strength; low drive after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_strength_bit_q <= {sgp_pkg::NPORT{sgp_pkg::DS_RST}};
    end else if (wr_go && is_ds) begin
      drive_strength_bit_q[sel_port*8 +: 8] <= wbyte;
    end
  end

  // Pad outputs registered; reset keeps every driver off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_oe_n <= {56{1'b1}};
      pin_out <= 56'h00_0000_0000_0000;
      pin_pullup <= 56'h00_0000_0000_0000;
      pin_pulldown <= 56'h00_0000_0000_0000;
      pin_slew <= {sgp_pkg::NPORT{sgp_pkg::SE_RST}} & sgp_pkg::IMPL_MASK;
      pin_drive <= 56'h00_0000_0000_0000;
    end else begin
      // Reserved positions never drive
      pin_oe_n <= ~drv_en_d;
      pin_out <= drv_val_d;
      pin_pullup <= pu_d;
      pin_pulldown <= pd_d;
      pin_slew <= slew_limit_enable_bit_q & sgp_pkg::IMPL_MASK;
      pin_drive <= drive_strength_bit_q & sgp_pkg::IMPL_MASK;
    end
  end

  // Pin levels to peripherals; analog pins give no digital input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func_in <= 56'h00_0000_0000_0000;
      first_timer_module_clk <= 1'b0;
      second_timer_module_clk <= 1'b0;
    end else begin
      func_in <= pin_sync & ~analog_en & sgp_pkg::IMPL_MASK;
      // Timer clocks taken from port D unless analog
      first_timer_module_clk <= pin_sync[sgp_pkg::TMR1_CLK_BIT] &
        ~analog_en[sgp_pkg::TMR1_CLK_BIT];
      second_timer_module_clk <= pin_sync[sgp_pkg::TMR2_CLK_BIT] &
        ~analog_en[sgp_pkg::TMR2_CLK_BIT];
    end
  end

  // Unimplemented positions never drive or pull
  chk_resv_never_drive: assert property (@(posedge pclk) disable iff (!presetn)
    ((~pin_oe_n | pin_pullup | pin_pulldown) & ~sgp_pkg::IMPL_MASK) == 56'h0)
    else $error("reserved pin driven or pulled");

  // Analog claim leaves no digital driver
  chk_adc_no_drive: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 ((~pin_oe_n) & $past(analog_en)) == 56'h0)
    else $error("analog pin still driven");

  // Pullup never on with a driver or analog
  chk_pullup_off_out: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (pin_pullup & (~pin_oe_n | $past(analog_en))) == 56'h0)
    else $error("pullup on an output pin");

  // Peripheral output claims drive the pin next cycle
  chk_periph_dir: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 ($past(func_en & func_oe & ~analog_en) & sgp_pkg::IMPL_MASK & pin_oe_n) == 56'h0)
    else $error("peripheral output not driven");

  // Peripheral data on owned output pins
  chk_periph_data: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 ((pin_out ^ $past(func_out)) &
      $past(func_en & func_oe & ~analog_en) & sgp_pkg::IMPL_MASK) == 56'h0)
    else $error("peripheral data not on pin");

  // Free pins follow the direction bit
  chk_gpio_fallback: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 ((~pin_oe_n ^ $past(pin_direction_bit_q)) &
      $past(~func_en & ~analog_en) & sgp_pkg::IMPL_MASK) == 56'h0)
    else $error("free pin ignores direction bit");

  // Pulldown follows keypad rising-edge selection
  chk_keypad_pulldown: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 pin_pulldown == $past(keypad_pin_enable & keypad_edge_select & ~analog_en &
      sgp_pkg::PD_CAP_MASK))
    else $error("pulldown selection wrong");

  // Answer lands in the first access cycle, upper bits clear
  chk_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> (pready && prdata[31:8] == 24'h00_0000))
    else $error("apb answer late or upper bits set");

  // Direction register write lands one cycle after commit
  chk_dir_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_go && is_dir) |=> pin_direction_bit_q[$past(sel_port)*8 +: 8] == $past(wbyte))
    else $error("direction write lost");
endmodule

/* verif/sgp_pad_model.sv */
// Pad model: resolves each package pin from the block and an outside driver
`timescale 1ns/1ns
module sgp_pad_model (
  input wire logic pclk,
  input wire logic [55:0] pin_out,
  input wire logic [55:0] pin_oe_n,
  input wire logic [55:0] pin_pullup,
  input wire logic [55:0] pin_pulldown,
  input wire logic [55:0] ext_drv,
  input wire logic [55:0] ext_lvl,
  output logic [55:0] pin_in
);
  // Floating level flips every cycle, so a lost pull never reads as stable
  logic [55:0] float_q = 56'h0;

  // Free-running pattern for undriven, unpulled pads
  always @(posedge pclk) begin
    float_q <= ~float_q;
  end

  // Block wins where it drives, then the outside driver, then the pulls
  always_comb begin
    for (int i = 0; i < 56; i++) begin
      if (!pin_oe_n[i]) begin
        pin_in[i] = pin_out[i];
      end else if (ext_drv[i]) begin
        pin_in[i] = ext_lvl[i];
      end else if (pin_pullup[i]) begin
        pin_in[i] = 1'b1;
      end else if (pin_pulldown[i]) begin
        pin_in[i] = 1'b0;
      end else begin
        pin_in[i] = float_q[i];
      end
    end
  end
endmodule

/* verif/tb_shared_gpio_port_control.sv */
// Self-checking bench for the seven-port GPIO block
`timescale 1ns/1ns
module tb_shared_gpio_port_control;
  localparam logic [55:0] IM = sgp_pkg::IMPL_MASK;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [55:0] pin_in, pin_out, pin_oe_n, pin_pullup, pin_pulldown, pin_slew, pin_drive;
  logic [55:0] func_en = 56'h0;
  logic [55:0] func_oe = 56'h0;
  logic [55:0] func_out = 56'h0;
  logic [55:0] analog_en = 56'h0;
  logic [55:0] keypad_pin_enable = 56'h0;
  logic [55:0] keypad_edge_select = 56'h0;
  logic [55:0] ext_lvl = 56'h0;
  // Pads that the outside world lets go of wherever the block pulls them
  logic [55:0] ext_rel = 56'h0;
  logic [55:0] func_in;
  logic tmr1_clk, tmr2_clk;
  // Reference register images, one byte per port
  logic [7:0] m_dat[7], m_dir[7], m_pe[7], m_se[7], m_ds[7];
  int mismatches = 0;
  int check_count = 0;
  int cyc = 0;

  sgp_gpio i_sgp_gpio (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pullup(pin_pullup), .pin_pulldown(pin_pulldown), .pin_slew(pin_slew),
    .pin_drive(pin_drive), .func_en(func_en), .func_oe(func_oe), .func_out(func_out),
    .analog_en(analog_en), .keypad_pin_enable(keypad_pin_enable),
    .keypad_edge_select(keypad_edge_select), .func_in(func_in),
    .first_timer_module_clk(tmr1_clk), .second_timer_module_clk(tmr2_clk));

  // Outside world releases some pulled pads, so the pulls alone set their level
  sgp_pad_model i_sgp_pad_model (.pclk(pclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pullup(pin_pullup), .pin_pulldown(pin_pulldown),
    .ext_drv(~(ext_rel & (pin_pullup | pin_pulldown))),
    .ext_lvl(ext_lvl), .pin_in(pin_in));

  // 250 MHz bus clock
  always #2 pclk = ~pclk;

  // Hang guard, far above the roughly 5400 cycles the tests need
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      finish_test();
    end
  end

  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Register-side comparison
  task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Pin-side comparison
  task automatic cmp_vec(input logic [55:0] got, input logic [55:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Byte addresses of page-zero and high-page registers
  function automatic logic [11:0] pz(input int p, input logic [2:0] o);
    return {sgp_pkg::PAGE_ZERO, 8'h00} + 12'(p * 8) + 12'(o);
  endfunction
  function automatic logic [11:0] hp(input int p, input logic [3:0] o);
    return {sgp_pkg::PAGE_HIGH, 8'h00} + 12'(p * 16) + 12'(o);
  endfunction

  // Random value limited to implemented pins
  function automatic logic [55:0] r56();
    return 56'({$urandom(), $urandom()}) & IM;
  endfunction

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     input logic xerr, output logic [31:0] rd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    cmp_rd({31'h0, pslverr}, {31'h0, xerr}, "error response");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Read a mapped register and compare with the reference byte
  task automatic rreg(input logic [11:0] a, input logic [7:0] exp);
    logic [31:0] rd;
    apb(1'b0, a, 32'h0, 1'b0, rd);
    cmp_rd(rd, {24'h0, exp}, "register read");
  endtask

  // Random write; reference keeps only implemented bits
  task automatic wrnd(input logic [11:0] a, input int p, output logic [7:0] m);
    logic [31:0] w, rd;
    w = $urandom();
    apb(1'b1, a, w, 1'b0, rd);
    m = w[7:0] & IM[p*8+:8];
  endtask

  // Read back every pad-control and direction register
  task automatic check_regs();
    for (int p = 0; p < 7; p++) begin
      rreg(pz(p, sgp_pkg::OFF_DIR), m_dir[p]);
      rreg(hp(p, sgp_pkg::OFF_PE), m_pe[p]);
      rreg(hp(p, sgp_pkg::OFF_SE), m_se[p]);
      rreg(hp(p, sgp_pkg::OFF_DS), m_ds[p]);
    end
  endtask

  // Reference ownership resolution compared with the pads and data reads
  task automatic check_pins();
    logic [55:0] dat, dir, pe, se, ds, ana, own, drv, out, pd, pu, lvl, rel;
    for (int p = 0; p < 7; p++) begin
      dat[p*8+:8] = m_dat[p];
      dir[p*8+:8] = m_dir[p];
      pe[p*8+:8] = m_pe[p];
      se[p*8+:8] = m_se[p];
      ds[p*8+:8] = m_ds[p];
    end
    ana = analog_en;
    own = func_en & ~ana & func_oe;
    drv = (own | (~func_en & dir)) & ~ana;
    out = (own & func_out) | (~own & dat);
    pd = sgp_pkg::PD_CAP_MASK & keypad_pin_enable & keypad_edge_select & ~ana;
    pu = pe & ~drv & ~ana & ~pd;
    // Driven pads sit at the block output, released pads at the pull level, others at the outside level
    rel = ext_rel & (pu | pd);
    lvl = (drv & out) | (~drv & ~rel & ext_lvl) | (~drv & rel & pu);
    cmp_vec(pin_oe_n, ~drv, "oe_n");
    cmp_vec(pin_out & drv, out & drv, "out");
    cmp_vec(pin_pullup, pu, "pullup");
    cmp_vec(pin_pulldown, pd, "pulldown");
    cmp_vec(pin_slew, se, "slew");
    cmp_vec(pin_drive, ds, "drive");
    cmp_vec(func_in & IM, lvl & ~ana, "func_in");
    cmp_vec({54'h0, tmr2_clk, tmr1_clk}, {54'h0, lvl[25:24] & ~ana[25:24]}, "tclk");
    for (int p = 0; p < 7; p++) begin
      rreg(pz(p, sgp_pkg::OFF_DATA),
           ((dir[p*8+:8] & dat[p*8+:8]) | (~dir[p*8+:8] & lvl[p*8+:8])) & ~ana[p*8+:8] &
           IM[p*8+:8]);
    end
  endtask

  // Main sequence
  initial begin
    logic [31:0] rd;
    logic [11:0] bad[4];
    bad = '{12'h038, 12'h10C, 12'h200, 12'h001};
    void'($urandom(40));
    for (int p = 0; p < 7; p++) begin
      m_dat[p] = 8'h00;
      m_dir[p] = 8'h00;
      m_pe[p] = 8'h00;
      m_se[p] = IM[p*8+:8];
      m_ds[p] = 8'h00;
    end
    repeat (5) @(posedge pclk);
    // Pads are inputs under port control while reset holds
    cmp_vec(pin_oe_n, 56'hFFFFFFFFFFFFFF, "oe_n in reset");
    cmp_vec(pin_slew, IM, "slew in reset");
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    check_regs();
    check_pins();
    $display("test reset done");
    // Unmapped and unaligned accesses: error, zero data, no side effect on direction or pad-control registers
    foreach (bad[i]) begin
      apb(1'b1, bad[i], 32'hFFFFFFFF, 1'b1, rd);
      apb(1'b0, bad[i], 32'h0, 1'b1, rd);
      cmp_rd(rd, 32'h0, "unmapped read");
    end
    check_regs();
    $display("test unmapped done");
    // Random registers and peripheral claims against the reference
    for (int it = 0; it < 24; it++) begin
      for (int p = 0; p < 7; p++) begin
        wrnd(pz(p, sgp_pkg::OFF_DATA), p, m_dat[p]);
        wrnd(pz(p, sgp_pkg::OFF_DIR), p, m_dir[p]);
        wrnd(hp(p, sgp_pkg::OFF_PE), p, m_pe[p]);
        wrnd(hp(p, sgp_pkg::OFF_SE), p, m_se[p]);
        wrnd(hp(p, sgp_pkg::OFF_DS), p, m_ds[p]);
      end
      @(posedge pclk);
      // Early passes leave peripherals idle so the pins fall back to port control
      func_en <= (it < 3) ? 56'h0 : r56();
      func_oe <= r56();
      func_out <= r56();
      analog_en <= (it < 3) ? 56'h0 : r56() & r56();
      keypad_pin_enable <= r56();
      keypad_edge_select <= r56();
      ext_lvl <= r56();
      ext_rel <= r56();
      repeat (5) @(posedge pclk);
      check_regs();
      check_pins();
    end
    $display("test sharing done");
    finish_test();
  end
endmodule
